// [logic/clock_switch_defs.vh]
// Constants for the clock switch control and status block.
// Assumes inclusion by bare name from the logic/ folder.
`ifndef CLOCK_SWITCH_DEFS_VH
`define CLOCK_SWITCH_DEFS_VH
`define ADDR_W 4
`define OFF_REQUEST 4'h0
`define OFF_CURRENT 4'h1
`define OFF_CONTROL3 4'h2
`define OFF_IRQ_STATUS 4'h3
`define OFF_IRQ_MASK 4'h4
`define BIT_HOLD 7
`define BIT_POWER 6
`define BIT_BYPASS 5
`define BIT_COMPLETE 4
`define BIT_READY 3
`define IRQ_BIT_READY 0
`define IRQ_BIT_DONE 1
`define RST_REQUEST 7'h00
`define RST_CONTROL 3'h0
`define RST_IRQ 2'h0
`define SETTLE_NS 200
// Settle time in 50 ns clock cycles, sized to match the settle counter
`define SETTLE_CYC 8'h04
`endif

// [logic/sync_two.v]
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes an asynchronous active-low reset.
`timescale 1ns/1ps
module sync_two (
   input wire clk_i,
   input wire rst_n_i,
   input wire d_i,
   output wire q_o
);
   reg s1_q;
   reg s2_q;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
      end
   end
   assign q_o = s2_q;
endmodule // sync_two

// [logic/source_select_mux.v]
// Picks the ready level of the requested oscillator source.
// Assumes ready inputs are already synchronised.
`timescale 1ns/1ps
module source_select_mux (
   input wire [2:0] source_i,
   input wire [7:0] ready_vec_i,
   output wire ready_o
);
   assign ready_o = ready_vec_i[source_i];
endmodule // source_select_mux

// [logic/clock_switch_control.v]
// Third oscillator control register with clock switch sequencing.
// Assumes a plain register port on clk_i and oscillator ready levels from
// outside the clock domain, one per source code.
//
// Contract
// - Hold set: pause switch when requested oscillator ready, raise interrupt.
// - Hold clear: switch when requested oscillator ready, raise interrupt.
// - Without bypass, power bit picks high or low power secondary oscillator.
// - Bypass makes input pin an external clock; output pin unused.
// - Complete flag is one when requested equals current, zero while switching.
// - Ready flag is one only while switching and requested oscillator ready.
// - Low three bits read zero; writes there have no effect.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "clock_switch_defs.vh"
module clock_switch_control (
   input wire clk_i,
   input wire rst_n_i,
   input wire [`ADDR_W-1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire [7:0] osc_ready_i,
   output wire [2:0] current_source_o,
   output wire [3:0] current_div_o,
   output wire sosc_high_power_o,
   output wire sosc_low_power_o,
   output wire sosc_ext_clock_o,
   output wire sosc_out_enable_o,
   output wire irq_o
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_SETTLE = 3'b100;
   localparam [7:0] SETTLE_CYC = `SETTLE_CYC;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [6:0] request_q;
   reg [6:0] current_q;
   reg hold_q;
   reg power_q;
   reg bypass_q;
   reg [1:0] irq_status_q;
   reg [1:0] irq_mask_q;
   reg [7:0] settle_q;
   reg ready_seen_q;
   wire [7:0] ready_sync;
   wire req_ready;
   wire complete;
   wire switching;
   wire ready_flag;
   wire do_switch;
   wire [1:0] irq_set;
   wire wr_ctl;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_sync
         sync_two u_sync (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .d_i(osc_ready_i[g]),
            .q_o(ready_sync[g])
         );
      end
   endgenerate

   source_select_mux u_mux (
      .source_i(request_q[6:4]),
      .ready_vec_i(ready_sync),
      .ready_o(req_ready)
   );

   assign complete = (request_q == current_q);
   assign switching = ~complete;
   assign ready_flag = switching & req_ready & (state_q != ST_IDLE);
   assign wr_ctl = wr_i & (addr_i == `OFF_CONTROL3);
   // Hold is sampled at the switch moment, so a late write still holds it
   assign do_switch = (state_q == ST_SETTLE) & (settle_q == 8'h00) & ~hold_q;
   assign irq_set[`IRQ_BIT_READY] = ready_flag & ~ready_seen_q;
   assign irq_set[`IRQ_BIT_DONE] = do_switch;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (switching) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (complete) begin
               state_d = ST_IDLE;
            end else if (req_ready) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (do_switch | complete) begin
               state_d = ST_IDLE;
            end else if (!req_ready) begin
               state_d = ST_WAIT;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         request_q <= `RST_REQUEST;
         current_q <= `RST_REQUEST;
         hold_q <= 1'b0;
         power_q <= 1'b0;
         bypass_q <= 1'b0;
         irq_status_q <= `RST_IRQ;
         irq_mask_q <= `RST_IRQ;
         settle_q <= 8'h00;
         ready_seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ready_seen_q <= ready_flag;
         if (state_q == ST_WAIT && req_ready) begin
            settle_q <= SETTLE_CYC - 8'h01;
         end else if (settle_q != 8'h00) begin
            settle_q <= settle_q - 8'h01;
         end
         if (wr_i && addr_i == `OFF_REQUEST) begin
            request_q <= wdata_i[6:0];
         end
         if (do_switch) begin
            current_q <= request_q;
         end
         // Hardware clear beats a software write in the same cycle
         if (do_switch || (complete && state_q != ST_IDLE)) begin
            hold_q <= 1'b0;
         end else if (wr_ctl) begin
            hold_q <= wdata_i[`BIT_HOLD];
         end
         if (wr_ctl) begin
            power_q <= wdata_i[`BIT_POWER];
            bypass_q <= wdata_i[`BIT_BYPASS];
         end
         if (wr_i && addr_i == `OFF_IRQ_MASK) begin
            irq_mask_q <= wdata_i[1:0];
         end
         // Set wins over a write-one clear in the same cycle
         if (wr_i && addr_i == `OFF_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~wdata_i[1:0]) | irq_set;
         end else begin
            irq_status_q <= irq_status_q | irq_set;
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `OFF_REQUEST: rdata_o <= {1'b0, request_q};
            `OFF_CURRENT: rdata_o <= {1'b0, current_q};
            `OFF_CONTROL3: rdata_o <= {hold_q, power_q, bypass_q, complete, ready_flag, 3'h0};
            `OFF_IRQ_STATUS: rdata_o <= {6'h00, irq_status_q};
            `OFF_IRQ_MASK: rdata_o <= {6'h00, irq_mask_q};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   assign current_source_o = current_q[6:4];
   assign current_div_o = current_q[3:0];
   assign sosc_high_power_o = ~bypass_q & power_q;
   assign sosc_low_power_o = ~bypass_q & ~power_q;
   assign sosc_ext_clock_o = bypass_q;
   assign sosc_out_enable_o = ~bypass_q;
   assign irq_o = |(irq_status_q & irq_mask_q);
endmodule // clock_switch_control

// [verification/clock_switch_properties.sv]
// Port-level checker for clock_switch_control.
// Assumes one clock domain; bound to the design below.
`timescale 1ns/1ps
`include "clock_switch_defs.vh"
module clock_switch_properties (
   input wire clk_i,
   input wire rst_n_i,
   input wire [`ADDR_W-1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire [7:0] osc_ready_i,
   input wire [2:0] current_source_o,
   input wire [3:0] current_div_o,
   input wire sosc_high_power_o,
   input wire sosc_low_power_o,
   input wire sosc_ext_clock_o,
   input wire sosc_out_enable_o,
   input wire irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire ctl_wr = wr_i && addr_i == `OFF_CONTROL3;
   wire hi_wr = wdata_i[6] && !wdata_i[5];
   sequence s_rd_ctl;
      rd_i && addr_i == `OFF_CONTROL3;
   endsequence
   a_pins_bypass: assert property (sosc_ext_clock_o != sosc_out_enable_o)
      else $error("pin enables disagree");
   a_power_one_mode: assert property (sosc_ext_clock_o || sosc_high_power_o != sosc_low_power_o)
      else $error("power mode not exclusive");
   a_bypass_power_off: assert property (sosc_ext_clock_o |-> !sosc_high_power_o && !sosc_low_power_o)
      else $error("power mode used in bypass");
   a_write_power: assert property (ctl_wr |=> sosc_high_power_o == $past(hi_wr))
      else $error("power write not applied");
   a_write_bypass: assert property (ctl_wr |=> sosc_ext_clock_o == $past(wdata_i[5]))
      else $error("bypass write not applied");
   a_read_low_zero: assert property (s_rd_ctl |=> rdata_o[2:0] == 3'h0)
      else $error("low bits not zero");
   a_ready_not_done: assert property (s_rd_ctl ##1 rdata_o[3] |-> !rdata_o[4])
      else $error("ready and complete together");
   a_read_current: assert property (rd_i && addr_i == `OFF_CURRENT |=>
      rdata_o == {1'b0, $past(current_source_o), $past(current_div_o)})
      else $error("current read mismatch");
endmodule // clock_switch_properties
bind clock_switch_control clock_switch_properties u_clock_switch_properties (.clk_i, .rst_n_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .osc_ready_i, .current_source_o, .current_div_o,
   .sosc_high_power_o, .sosc_low_power_o, .sosc_ext_clock_o, .sosc_out_enable_o, .irq_o);

// [verification/testbench.sv]
// Self-checking bench: register port, held and free switches, irq.
// Assumes the logic/ files are compiled first.
`timescale 1ns/1ps
`include "clock_switch_defs.vh"
module testbench;
   logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, pend = 0;
   logic [3:0] addr_i = 0, current_div_o;
   logic [7:0] wdata_i = 0, osc_ready_i = 0, rdata_o;
   logic [2:0] current_source_o;
   logic sosc_high_power_o, sosc_low_power_o, sosc_ext_clock_o, sosc_out_enable_o, irq_o;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h000126B1;
   int n_errors = 0, compares = 0, cyc = 0;
   always #25 clk_i = ~clk_i;
   clock_switch_control u_clock_switch_control (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .osc_ready_i, .current_source_o, .current_div_o, .sosc_high_power_o,
      .sosc_low_power_o, .sosc_ext_clock_o, .sosc_out_enable_o, .irq_o);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge clk_i) begin
      pend <= rd_i;
      if (pend) chk(rdata_o, exp_q.pop_front());
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      seed = xs(seed);
      osc_ready_i = seed[7:0] & 8'hF7;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`OFF_CONTROL3, 8'h10);
      rd(`OFF_IRQ_MASK, 8'h00);
      wr(`OFF_CONTROL3, 8'h6F);
      rd(`OFF_CONTROL3, 8'h70);
      rd(4'h7, 8'h00);
      wr(`OFF_IRQ_MASK, 8'h03);
      wr(`OFF_CONTROL3, 8'h80);
      wr(`OFF_REQUEST, 8'h35);
      rd(`OFF_CONTROL3, 8'h80);
      osc_ready_i <= osc_ready_i | 8'h08;
      repeat (12) @(posedge clk_i);
      rd(`OFF_CONTROL3, 8'h88);
      rd(`OFF_CURRENT, 8'h00);
      rd(`OFF_IRQ_STATUS, 8'h01);
      wr(`OFF_CONTROL3, 8'h00);
      repeat (12) @(posedge clk_i);
      rd(`OFF_CONTROL3, 8'h10);
      rd(`OFF_CURRENT, 8'h35);
      rd(`OFF_IRQ_STATUS, 8'h03);
      wr(`OFF_IRQ_STATUS, 8'h03);
      rd(`OFF_IRQ_STATUS, 8'h00);
      wr(`OFF_IRQ_MASK, 8'h00);
      seed = xs(seed);
      osc_ready_i <= seed[7:0] | 8'h01;
      wr(`OFF_REQUEST, 8'h02);
      repeat (12) @(posedge clk_i);
      rd(`OFF_CURRENT, 8'h02);
      #1;
      chk({7'h00, irq_o}, 8'h00);
      wr(`OFF_IRQ_MASK, 8'h02);
      @(posedge clk_i);
      #1;
      chk({7'h00, irq_o}, 8'h01);
      repeat (3) @(posedge clk_i);
      tally_and_finish();
   end
endmodule // testbench
